// ---- hw/cgm_regs.vh ----
// Register map, field positions, reset values and timing figures of the clock gating block
// Behaviour
// - Enable write bit 0 starts processor clock
// - Disable write bit 0 stops processor clock
// - Enable write bit 7 starts USB clock
// - Disable write bit 7 stops USB clock
// - Enable bits 8-10 start programmable outputs
// - Disable bits 8-10 stop programmable outputs
// - Status bits 0, 7 show processor, USB
// - Status bits 8-10 show programmable outputs
// - Peripheral enable bits 2-31 start clocks
// - Peripheral disable bits 2-31 stop clocks
// - Peripheral status shows enabled peripheral clocks
// - Unimplemented peripheral bits change nothing
// - Oscillator control bit 0 enables crystal
// - Stable flag only after start-up time
// - Bypass bit 1 sets stable at once
// - Enable and bypass low clear stable
// - Start-up time is count times eight
// - Frequency counts main cycles in sixteen slow
// - Frequency valid only after count available
`ifndef CGM_REGS_VH
`define CGM_REGS_VH

// Byte offsets
`define CGM_SYS_CLK_ENABLE_OFS 8'h00
`define CGM_SYS_CLK_DISABLE_OFS 8'h04
`define CGM_SYS_CLK_STATUS_OFS 8'h08
`define CGM_PERIPH_CLK_ENABLE_OFS 8'h10
`define CGM_PERIPH_CLK_DISABLE_OFS 8'h14
`define CGM_PERIPH_CLK_STATUS_OFS 8'h18
`define CGM_MAIN_OSC_CONTROL_OFS 8'h20
`define CGM_MAIN_CLK_FREQ_OFS 8'h24

// Field positions
`define CGM_PROCESSOR_CLOCK_BIT 0
`define CGM_USB_PORT_CLOCK_BIT 7
`define CGM_PROG_CLOCK_LSB 8
`define CGM_PROG_CLOCK_MSB 10
`define CGM_PERIPH_LSB 2
`define CGM_PERIPH_MSB 31
`define CGM_MAIN_OSC_ON_BIT 0
`define CGM_OSC_BYPASS_BIT 1
`define CGM_OSC_COUNT_LSB 8
`define CGM_OSC_COUNT_MSB 15
`define CGM_FREQ_VALID_BIT 16

// Reset values
`define CGM_SYS_STATUS_RESET 32'h0000_0001
`define CGM_PERIPH_STATUS_RESET 32'h0000_0000
`define CGM_OSC_CONTROL_RESET 32'h0000_0000

// Timing figures, in slow clock cycles
`define CGM_OSC_COUNT_SCALE 8
`define CGM_FREQ_WINDOW 16

`endif

// ---- hw/cgm_clock_ctrl.v ----
// Clock gating and main oscillator control with its register port
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cgm_regs.vh"

// Block overview
//
// Register port
// - One cycle write strobe with address and data
// - One cycle read strobe with address
// - Read data registered, present only the cycle after the strobe
// - Read data returns to zero in every other cycle
// - No wait states; back to back strobes are fine
// - Read and write never share a cycle
//
// Set and clear pairs
// - Each gate is one flop
// - Enable offset writes set the flops named by ones
// - Disable offset writes clear the flops named by ones
// - Zero bits leave a flop alone
// - Set and clear live at separate offsets
// - So a set and a clear never meet in one cycle
// - Status offsets show the flops directly
// - Enable and disable offsets read as zero
//
// System gates
// - Processor gate comes out of reset on
// - Clearing it is how software idles the core
// - Core idling is the caller's business, not ours
// - USB port gate comes out of reset off
// - Programmable output gates come out of reset off
// - Output count is a parameter; default three
// - Bits above the last output are ignored
//
// Peripheral gates
// - Bits 0 and 1 have no peripheral behind them
// - A mask parameter says which identifiers exist
// - Missing identifiers keep a flop tied to zero
// - Tied flops keep the output straight from a register
// - Writes to missing identifiers change nothing at all
// - Status of a missing identifier reads zero
//
// Oscillator control
// - Enable, bypass and start-up count are plain fields
// - All three read back as written
// - Enable and bypass together is a software fault
// - Enable wins in that case; bypass is then ignored
// - Count is in units of eight slow clock cycles
// - A count of zero starts almost at once
// - Largest count gives 2040 slow clock cycles
//
// Oscillator state machine
// - Off: stable flag low
// - Start: counting slow clock edges toward target
// - Run: crystal up, stable flag high
// - Bypass: external clock, stable flag high at once
// - Clearing enable and bypass returns to off
// - Clearing enable with bypass set goes to bypass
// - Setting enable from bypass restarts the count
// - Stable flag follows the next state
// - So it moves one edge after the field update
//
// Slow clock and main clock pins
// - Both are foreign to the system clock
// - Each passes two flops before any logic looks
// - A third flop only remembers the old level
// - Rising edges are found from stages two and three
// - Edges may lag the pins by two or three cycles
// - Lag is the same for start and end of a window
// - So the measured counts are not biased by it
//
// Frequency measurement
// - Runs once per stable period
// - First slow edge after stable opens the window
// - Sixteen slow periods later the window closes
// - Main clock edges inside it are counted
// - The count is latched and the valid flag set
// - Counter saturates rather than wraps
// - Losing stable drops the result and the flag
// - A fresh stable period measures again
//
// Main clock speed limit
// - Edges are sampled by the system clock
// - Main clock must stay well below half of it
// - Below a quarter keeps every edge seen
// - Faster clocks read low; no error is flagged
//
// Reset
// - Asynchronous, active low
// - All gates off except the processor gate
// - Oscillator fields cleared, state off
// - Frequency result cleared, valid low
// - Read data zero
//
// What is not here
// - No clock muxing or division
// - No pll, no master clock select
// - No interrupt logic
// - Gate outputs are levels for a cell outside
// - Glitch-free gating is that cell's duty
//
// Hazards for users
// - Gate outputs change one edge after the write
// - Stable may drop while a measurement runs
// - Poll valid before trusting the count
// - Start-up time has a slow clock of slack
// - First slow edge may come anywhere in its period
//

module cgm_clock_ctrl #(
    parameter [31:0] PERIPH_IMPL = 32'hffff_fffc,
    parameter NUM_PROG = 3
) (
    input wire clk,
    input wire resetn,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire slow_clk_pin,
    input wire osc_in_pin,
    output reg processor_clock_on,
    output reg usb_port_clock,
    output reg [NUM_PROG-1:0] prog_clock_out_on,
    output reg [31:0] periph_clock_on,
    output reg main_osc_on,
    output reg osc_bypass_a,
    output reg main_osc_stable
);

    localparam OSC_OFF = 2'h0;
    localparam OSC_START = 2'h1;
    localparam OSC_RUN = 2'h2;
    localparam OSC_BYP = 2'h3;
    localparam [31:0] SYS_RST = `CGM_SYS_STATUS_RESET;
    localparam [31:0] OSC_RST = `CGM_OSC_CONTROL_RESET;

    // Write decode, one cycle strobes
    wire wr_sys_en = wr && (addr == `CGM_SYS_CLK_ENABLE_OFS);
    wire wr_sys_dis = wr && (addr == `CGM_SYS_CLK_DISABLE_OFS);
    wire wr_per_en = wr && (addr == `CGM_PERIPH_CLK_ENABLE_OFS);
    wire wr_per_dis = wr && (addr == `CGM_PERIPH_CLK_DISABLE_OFS);
    wire wr_osc = wr && (addr == `CGM_MAIN_OSC_CONTROL_OFS);

    // Pin synchronisers; stages two and three feed edge detection
    reg slow_s1, slow_s2, slow_s3;
    reg main_s1, main_s2, main_s3;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
            main_s1 <= 1'b0;
            main_s2 <= 1'b0;
            main_s3 <= 1'b0;
        end else begin
            slow_s1 <= slow_clk_pin;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
            main_s1 <= osc_in_pin;
            main_s2 <= main_s1;
            main_s3 <= main_s2;
        end
    end
    // Main clock must stay below a quarter of clk to be counted faithfully
    wire slow_edge = slow_s2 & ~slow_s3;
    wire main_edge = main_s2 & ~main_s3;

    // Processor and USB clock gates; set on enable, clear on disable
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            processor_clock_on <= SYS_RST[`CGM_PROCESSOR_CLOCK_BIT];
            usb_port_clock <= 1'b0;
        end else begin
            if (wr_sys_en && wdata[`CGM_PROCESSOR_CLOCK_BIT])
                processor_clock_on <= 1'b1;
            else if (wr_sys_dis && wdata[`CGM_PROCESSOR_CLOCK_BIT])
                processor_clock_on <= 1'b0;
            if (wr_sys_en && wdata[`CGM_USB_PORT_CLOCK_BIT])
                usb_port_clock <= 1'b1;
            else if (wr_sys_dis && wdata[`CGM_USB_PORT_CLOCK_BIT])
                usb_port_clock <= 1'b0;
        end
    end

    // Programmable output gates, one flop per output
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PROG; gp = gp + 1) begin : g_prog
            always @(posedge clk or negedge resetn) begin
                if (!resetn)
                    prog_clock_out_on[gp] <= 1'b0;
                else if (wr_sys_en && wdata[`CGM_PROG_CLOCK_LSB + gp])
                    prog_clock_out_on[gp] <= 1'b1;
                else if (wr_sys_dis && wdata[`CGM_PROG_CLOCK_LSB + gp])
                    prog_clock_out_on[gp] <= 1'b0;
            end
        end
    endgenerate

    // Peripheral gates; bits without a peripheral stay zero for good
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_per
            if (PERIPH_IMPL[gi] && gi >= `CGM_PERIPH_LSB) begin : g_impl
                always @(posedge clk or negedge resetn) begin
                    if (!resetn)
                        periph_clock_on[gi] <= 1'b0;
                    else if (wr_per_en && wdata[gi])
                        periph_clock_on[gi] <= 1'b1;
                    else if (wr_per_dis && wdata[gi])
                        periph_clock_on[gi] <= 1'b0;
                end
            end else begin : g_none
                always @(posedge clk or negedge resetn) begin
                    if (!resetn)
                        periph_clock_on[gi] <= 1'b0;
                    else
                        periph_clock_on[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Oscillator control fields
    reg [7:0] osc_startup_count;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            main_osc_on <= OSC_RST[`CGM_MAIN_OSC_ON_BIT];
            osc_bypass_a <= 1'b0;
            osc_startup_count <= 8'h00;
        end else if (wr_osc) begin
            // Both bits set at once is a software fault; enable wins then
            main_osc_on <= wdata[`CGM_MAIN_OSC_ON_BIT];
            osc_bypass_a <= wdata[`CGM_OSC_BYPASS_BIT];
            osc_startup_count <= wdata[`CGM_OSC_COUNT_MSB:`CGM_OSC_COUNT_LSB];
        end
    end

    // Start-up target in slow clock cycles
    wire [31:0] startup_prod = osc_startup_count * `CGM_OSC_COUNT_SCALE;
    wire [10:0] startup_target = startup_prod[10:0];
    reg [1:0] osc_state;
    reg [1:0] next_osc_state;
    reg [10:0] startup_cnt;

    always @* begin
        next_osc_state = osc_state;
        case (osc_state)
            OSC_OFF: begin
                if (main_osc_on)
                    next_osc_state = OSC_START;
                else if (osc_bypass_a)
                    next_osc_state = OSC_BYP;
            end
            OSC_START: begin
                if (!main_osc_on)
                    next_osc_state = osc_bypass_a ? OSC_BYP : OSC_OFF;
                else if (startup_cnt >= startup_target)
                    next_osc_state = OSC_RUN;
            end
            OSC_RUN: begin
                if (!main_osc_on)
                    next_osc_state = osc_bypass_a ? OSC_BYP : OSC_OFF;
            end
            OSC_BYP: begin
                if (main_osc_on)
                    next_osc_state = OSC_START;
                else if (!osc_bypass_a)
                    next_osc_state = OSC_OFF;
            end
            default: next_osc_state = OSC_OFF;
        endcase
    end

    // Start-up counter advances on slow clock edges only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_state <= OSC_OFF;
            startup_cnt <= 11'h000;
            main_osc_stable <= 1'b0;
        end else begin
            osc_state <= next_osc_state;
            if (osc_state != OSC_START)
                startup_cnt <= 11'h000;
            else if (slow_edge && startup_cnt != 11'h7ff)
                startup_cnt <= startup_cnt + 11'h001;
            main_osc_stable <= (next_osc_state == OSC_RUN) ||
                (next_osc_state == OSC_BYP);
        end
    end

    // Frequency measurement: one window per stable period
    reg [4:0] win_cnt;
    reg [15:0] main_cnt;
    reg [15:0] main_freq_count;
    reg main_freq_valid;
    reg win_open;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt <= 5'h00;
            main_cnt <= 16'h0000;
            main_freq_count <= 16'h0000;
            main_freq_valid <= 1'b0;
            win_open <= 1'b0;
        end else if (!main_osc_stable) begin
            // Result is dropped when the oscillator goes away
            win_cnt <= 5'h00;
            main_cnt <= 16'h0000;
            main_freq_count <= 16'h0000;
            main_freq_valid <= 1'b0;
            win_open <= 1'b0;
        end else if (!main_freq_valid) begin
            if (slow_edge) begin
                if (win_open && win_cnt == `CGM_FREQ_WINDOW - 1) begin
                    main_freq_count <= main_cnt;
                    main_freq_valid <= 1'b1;
                    win_open <= 1'b0;
                end else begin
                    win_open <= 1'b1;
                    win_cnt <= win_open ? win_cnt + 5'h01 : 5'h00;
                end
            end
            if (win_open && main_edge && main_cnt != 16'hffff)
                main_cnt <= main_cnt + 16'h0001;
        end
    end

    // Read mux; write-only and unmapped offsets read zero
    reg [31:0] next_rdata;
    integer k;
    always @* begin
        next_rdata = 32'h0000_0000;
        case (addr)
            `CGM_SYS_CLK_STATUS_OFS: begin
                next_rdata[`CGM_PROCESSOR_CLOCK_BIT] = processor_clock_on;
                next_rdata[`CGM_USB_PORT_CLOCK_BIT] = usb_port_clock;
                for (k = 0; k < NUM_PROG; k = k + 1)
                    next_rdata[`CGM_PROG_CLOCK_LSB + k] = prog_clock_out_on[k];
            end
            `CGM_PERIPH_CLK_STATUS_OFS: next_rdata = periph_clock_on;
            `CGM_MAIN_OSC_CONTROL_OFS: begin
                next_rdata[`CGM_MAIN_OSC_ON_BIT] = main_osc_on;
                next_rdata[`CGM_OSC_BYPASS_BIT] = osc_bypass_a;
                next_rdata[`CGM_OSC_COUNT_MSB:`CGM_OSC_COUNT_LSB] = osc_startup_count;
            end
            `CGM_MAIN_CLK_FREQ_OFS: begin
                next_rdata[15:0] = main_freq_count;
                next_rdata[`CGM_FREQ_VALID_BIT] = main_freq_valid;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            rdata <= 32'h0000_0000;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= 32'h0000_0000;
    end

endmodule
`default_nettype wire

// ---- sim/cgm_clock_ctrl_props.sv ----
// Port checks for the clock gating block
`timescale 1ns/10ps
`default_nettype none
module cgm_clock_ctrl_props #(
    parameter [31:0] PERIPH_IMPL = 32'hffff_fffc,
    parameter NUM_PROG = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic slow_clk_pin,
    input wire logic osc_in_pin,
    input wire logic processor_clock_on,
    input wire logic usb_port_clock,
    input wire logic [NUM_PROG-1:0] prog_clock_out_on,
    input wire logic [31:0] periph_clock_on,
    input wire logic main_osc_on,
    input wire logic osc_bypass_a,
    input wire logic main_osc_stable
);
    // Decoded writes; bus never overlaps read and write, so gates hold during a read
    wire sys_set = wr && addr == 8'h00;
    wire sys_clr = wr && addr == 8'h04;
    wire pid_set = wr && addr == 8'h10;
    wire pid_clr = wr && addr == 8'h14;
    wire osc_wr = wr && addr == 8'h20;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    chk_cpu_start: assert property (sys_set && wdata[0] |=> processor_clock_on)
        else $error("cpu gate not set");
    chk_cpu_stop: assert property (sys_clr && wdata[0] |=> !processor_clock_on)
        else $error("cpu gate not cleared");
    chk_usb_start: assert property (sys_set && wdata[7] |=> usb_port_clock)
        else $error("usb gate not set");
    chk_usb_stop: assert property (sys_clr && wdata[7] |=> !usb_port_clock)
        else $error("usb gate not cleared");
    chk_prog_start: assert property (sys_set |=> &(prog_clock_out_on | ~$past(wdata[10:8])))
        else $error("output gate not set");
    chk_prog_stop: assert property (sys_clr |=> !(|(prog_clock_out_on & $past(wdata[10:8]))))
        else $error("output gate not cleared");
    chk_sys_status: assert property (rd && addr == 8'h08 |=> rdata == {21'h0,
        $past(prog_clock_out_on), $past(usb_port_clock), 6'h0, $past(processor_clock_on)})
        else $error("system status wrong");
    chk_pid_start: assert property (pid_set |=>
        (periph_clock_on & $past(wdata)) == ($past(wdata) & PERIPH_IMPL))
        else $error("peripheral gate wrong after set");
    chk_pid_stop: assert property (pid_clr |=> !(|(periph_clock_on & $past(wdata))))
        else $error("peripheral gate not cleared");
    chk_pid_status: assert property (rd && addr == 8'h18 |=> rdata == $past(periph_clock_on))
        else $error("peripheral status wrong");
    chk_osc_bypass: assert property (osc_wr && wdata[1:0] == 2'b10 |-> ##2 main_osc_stable)
        else $error("bypass did not raise stable");
    chk_osc_clear: assert property (osc_wr && wdata[1:0] == 2'b00 |-> ##2 !main_osc_stable)
        else $error("stable not cleared");
    chk_wo_zero: assert property (rd && (addr & 8'heb) == 8'h00 |=> rdata == 32'h0)
        else $error("write-only read not zero");
endmodule
bind cgm_clock_ctrl cgm_clock_ctrl_props #(.PERIPH_IMPL(PERIPH_IMPL), .NUM_PROG(NUM_PROG)) u_props (
    .clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .slow_clk_pin, .osc_in_pin,
    .processor_clock_on, .usb_port_clock, .prog_clock_out_on, .periph_clock_on,
    .main_osc_on, .osc_bypass_a, .main_osc_stable);
`default_nettype wire

// ---- sim/test_cgm_clock_ctrl.sv ----
// Register-level bench for the clock gating block
`timescale 1ns/10ps
`default_nettype none
module test_cgm_clock_ctrl;
    localparam int SLOW_HALF = 400;
    localparam int MAIN_HALF = 100;
    localparam int SLOW_CYC = 2 * SLOW_HALF / 40;
    localparam int FREQ = 16 * SLOW_HALF / MAIN_HALF;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic slow_clk_pin = 1'b0, osc_in_pin = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, periph_clock_on, v, e;
    logic [2:0] prog_clock_out_on;
    logic processor_clock_on, usb_port_clock, main_osc_on, osc_bypass_a, main_osc_stable;
    int n_mismatch = 0, check_count = 0, cycles = 0, i;
    int pos[5] = '{0, 7, 8, 9, 10};
    wire [31:0] gates = {21'h0, prog_clock_out_on, usb_port_clock, 6'h0, processor_clock_on};

    // Top identifier left unimplemented so its gate must stay off
    cgm_clock_ctrl #(.PERIPH_IMPL(32'h7fff_fffc), .NUM_PROG(3)) DUT (.clk, .resetn, .addr,
        .wdata, .wr, .rd, .rdata, .slow_clk_pin, .osc_in_pin, .processor_clock_on,
        .usb_port_clock, .prog_clock_out_on, .periph_clock_on, .main_osc_on,
        .osc_bypass_a, .main_osc_stable);

    // System clock and two pin clocks, unrelated in phase
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        forever #SLOW_HALF slow_clk_pin = ~slow_clk_pin;
    end
    initial begin
        #7;
        forever #MAIN_HALF osc_in_pin = ~osc_in_pin;
    end

    // Hang guard, well above the oscillator and frequency waits
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        check(name, exp, d);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd_chk("sys status", 8'h08, 32'h1);
        rd_chk("pid status", 8'h18, 32'h0);
        rd_chk("freq", 8'h24, 32'h0);
        // Stop all, then zero writes must change nothing
        wr_reg(8'h04, 32'h781);
        wr_reg(8'h00, 32'h0);
        check("gates", 32'h0, gates);
        e = 32'h0;
        for (i = 0; i < 5; i++) begin
            e[pos[i]] = 1'b1;
            wr_reg(8'h00, 32'h1 << pos[i]);
            check("gates", e, gates);
        end
        wr_reg(8'h04, 32'h280);
        // Status and unmapped writes are ignored
        wr_reg(8'h08, 32'h781);
        wr_reg(8'h0c, 32'hffff_ffff);
        rd_chk("sys status", 8'h08, 32'h501);
        rd_chk("unmapped", 8'h0c, 32'h0);
        rd_chk("sys enable", 8'h00, 32'h0);
        wr_reg(8'h10, 32'hffff_ffff);
        check("pid gates", 32'h7fff_fffc, periph_clock_on);
        wr_reg(8'h14, 32'h110);
        rd_chk("pid status", 8'h18, 32'h7fff_feec);
        rd_chk("pid disable", 8'h14, 32'h0);
        // Crystal start-up with a count of one
        wr_reg(8'h20, 32'h101);
        check("osc on", 32'h1, {31'h0, main_osc_on});
        rd_chk("osc control", 8'h20, 32'h101);
        for (i = 0; i < 400 && main_osc_stable !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check("startup", 32'h1, {31'h0, i >= 7 * SLOW_CYC - 4 && i <= 8 * SLOW_CYC + 6});
        for (i = 0; i < 300 && v[16] !== 1'b1; i++) begin
            rd_reg(8'h24, v);
        end
        check("freq valid", 32'h1, {31'h0, v[16]});
        check("freq count", 32'h1, {31'h0, v[15:0] >= FREQ - 1 && v[15:0] <= FREQ + 1});
        wr_reg(8'h20, 32'h0);
        @(posedge clk);
        #1;
        check("stable", 32'h0, {31'h0, main_osc_stable});
        rd_chk("freq", 8'h24, 32'h0);
        wr_reg(8'h20, 32'h2);
        @(posedge clk);
        #1;
        check("stable", 32'h1, {31'h0, main_osc_stable});
        print_verdict();
    end
endmodule
`default_nettype wire
